// File: logic/blk_xfer_pkg.sv
// constants, codes and carrier types for the block-sequenced image exchange
`default_nettype none

package blk_xfer_pkg;

  localparam int WORD_W = 16;
  localparam int DB_AW  = 12;
  localparam int BLK_W  = 7;
  localparam int IDX_W  = 6;

  // image layout, word offsets
  localparam logic [IDX_W-1:0] WIDX_CODE      = 6'h00;
  localparam logic [IDX_W-1:0] WIDX_FIRST     = 6'h01;
  localparam logic [IDX_W-1:0] WIDX_LAST_DATA = 6'h28;
  localparam logic [IDX_W-1:0] WIDX_TAIL      = 6'h29;

  // send sequencing: count 1..42, one image word per count
  localparam logic [IDX_W-1:0] CNT_SEND_START = 6'h01;
  localparam logic [IDX_W-1:0] CNT_LAST_DATA  = 6'h29;
  localparam logic [IDX_W-1:0] CNT_SEND_END   = 6'h2A;

  localparam logic [WORD_W-1:0] BLK_WORDS_W = 16'h0028;
  localparam logic [WORD_W-1:0] BLK_ROUND_W = 16'h0027;

  // identification codes
  localparam logic [WORD_W-1:0] CODE_NULL     = 16'h0000;
  localparam logic [WORD_W-1:0] CODE_NULL_NEG = 16'hFFFF;
  localparam logic [WORD_W-1:0] CODE_DATA_MIN = 16'h0001;
  localparam logic [WORD_W-1:0] CODE_DATA_MAX = 16'h007D;
  localparam logic [WORD_W-1:0] CODE_INIT_MIN = 16'h03E8;
  localparam logic [WORD_W-1:0] CODE_INIT_MAX = 16'h0465;
  localparam logic [WORD_W-1:0] CODE_STATUS   = 16'h2422;
  localparam logic [WORD_W-1:0] CODE_SPEC_MIN = 16'h26AD;
  localparam logic [WORD_W-1:0] CODE_SPEC_MAX = 16'h270F;
  localparam logic [WORD_W-1:0] CODE_EVT_P1   = 16'h26AD;
  localparam logic [WORD_W-1:0] CODE_EVT_P2   = 16'h26B7;
  localparam logic [WORD_W-1:0] CODE_CMD_P1   = 16'h26AE;
  localparam logic [WORD_W-1:0] CODE_CMD_P2   = 16'h26B8;
  localparam logic [WORD_W-1:0] CODE_ERR_P1   = 16'h26DE;
  localparam logic [WORD_W-1:0] CODE_ERR_P2   = 16'h26DF;
  localparam logic [WORD_W-1:0] CODE_SLV_P1   = 16'h26E8;
  localparam logic [WORD_W-1:0] CODE_SLV_P2   = 16'h26E9;
  localparam logic [WORD_W-1:0] CODE_WARM     = 16'h270E;
  localparam logic [WORD_W-1:0] CODE_COLD     = 16'h270F;

  // values after reset
  localparam logic [BLK_W-1:0]  BLK_FIRST  = 7'h01;
  localparam logic [IDX_W-1:0]  CNT_RESET  = 6'h00;
  localparam logic [WORD_W-1:0] CODE_RESET = 16'h0000;

  typedef enum logic [0:0] {ST_RECV, ST_SEND} state_t;

  typedef struct packed {
    logic              valid;
    logic [IDX_W-1:0]  idx;
    logic [WORD_W-1:0] data;
  } img_word_t;

  typedef struct packed {
    logic [DB_AW-1:0]  read_start;
    logic [WORD_W-1:0] read_count;
    logic [DB_AW-1:0]  write_start;
    logic [WORD_W-1:0] write_count;
  } cfg_t;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] code;
  } msg_req_t;

  typedef struct packed {
    logic              done;
    logic              accepted;
    logic [WORD_W-1:0] code;
  } msg_rsp_t;

  typedef struct packed {
    logic              we;
    logic [DB_AW-1:0]  addr;
    logic [WORD_W-1:0] wdata;
  } db_port_t;

endpackage

`default_nettype wire

// File: logic/db_ram.sv
// two-port word database with registered read data on each port
`timescale 1ns/1ns
`default_nettype none

module db_ram
  import blk_xfer_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset_n,
  input  wire db_port_t          i_a,
  output logic [WORD_W-1:0]      o_a_rdata,
  input  wire db_port_t          i_b,
  output logic [WORD_W-1:0]      o_b_rdata
);

  logic [WORD_W-1:0] mem [0:(1<<DB_AW)-1];
  logic [WORD_W-1:0] a_rdata_q;
  logic [WORD_W-1:0] b_rdata_q;

  // same-address writes in one cycle: port a is applied last and wins
  always_ff @(posedge i_ref_clk) begin
    if (i_b.we) begin
      mem[i_b.addr] <= i_b.wdata;
    end
    if (i_a.we) begin
      mem[i_a.addr] <= i_a.wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      a_rdata_q <= CODE_RESET;
      b_rdata_q <= CODE_RESET;
    end else begin
      a_rdata_q <= mem[i_a.addr];
      b_rdata_q <= mem[i_b.addr];
    end
  end

  assign o_a_rdata = a_rdata_q;
  assign o_b_rdata = b_rdata_q;

endmodule

`default_nettype wire

// File: logic/block_image_xfer.sv
// image block exchange engine: code decode, block sequencing, database moves
`timescale 1ns/1ns
`default_nettype none

module block_image_xfer
  import blk_xfer_pkg::*;
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_reset_n,
  input  wire cfg_t          i_cfg,
  input  wire logic          i_port1_master,
  input  wire logic          i_port2_master,
  input  wire img_word_t     i_out_img,
  output logic               o_out_ready,
  output img_word_t          o_in_img,
  input  wire msg_req_t      i_msg_req,
  output msg_rsp_t           o_msg_rsp,
  input  wire db_port_t      i_drv,
  output logic [WORD_W-1:0]  o_drv_rdata,
  output logic               o_warm_restart,
  output logic               o_cold_restart
);

  function automatic logic is_null(input logic [WORD_W-1:0] c);
    return (c == CODE_NULL) || (c == CODE_NULL_NEG);
  endfunction

  function automatic logic is_data(input logic [WORD_W-1:0] c);
    return (c >= CODE_DATA_MIN) && (c <= CODE_DATA_MAX);
  endfunction

  function automatic logic is_init(input logic [WORD_W-1:0] c);
    return (c >= CODE_INIT_MIN) && (c <= CODE_INIT_MAX);
  endfunction

  function automatic logic is_special(input logic [WORD_W-1:0] c);
    return (c >= CODE_SPEC_MIN) && (c <= CODE_SPEC_MAX);
  endfunction

  state_t            state_q;
  state_t            state_d;
  logic [WORD_W-1:0] code_q;
  logic [WORD_W-1:0] code_d;
  logic [BLK_W-1:0]  wb_q;
  logic [BLK_W-1:0]  wb_d;
  logic [BLK_W-1:0]  rb_q;
  logic [BLK_W-1:0]  rb_d;
  logic [IDX_W-1:0]  cnt_q;
  logic [IDX_W-1:0]  cnt_d;
  logic              adv_q;
  logic              adv_d;
  logic              pend_q;
  logic              pend_d;
  logic [WORD_W-1:0] reply_q;
  logic [WORD_W-1:0] reply_d;
  img_word_t         img_q;
  img_word_t         img_d;
  logic              warm_q;
  logic              warm_d;
  logic              cold_q;
  logic              cold_d;
  msg_rsp_t          msg_q;
  msg_rsp_t          msg_d;

  db_port_t          mem_a;
  logic [WORD_W-1:0] mem_rdata;
  logic [WORD_W-1:0] rblk_full;
  logic [WORD_W-1:0] wblk_full;
  logic [BLK_W-1:0]  rblocks;
  logic [BLK_W-1:0]  wblocks;
  logic [BLK_W-1:0]  wn;
  logic [WORD_W-1:0] waddr_full;
  logic [WORD_W-1:0] raddr_full;
  logic [WORD_W-1:0] exp_code;
  logic [WORD_W-1:0] rd_code;
  logic              wr_block;
  logic              recv_end;

  // ceiling division by the block size; counts are small enough not to wrap
  assign rblk_full = (i_cfg.read_count + BLK_ROUND_W) / BLK_WORDS_W;
  assign wblk_full = (i_cfg.write_count + BLK_ROUND_W) / BLK_WORDS_W;
  assign rblocks   = rblk_full[BLK_W-1:0];
  assign wblocks   = wblk_full[BLK_W-1:0];

  // init codes reuse data placement with the 1000 offset removed
  assign wn = is_init(code_q) ? BLK_W'(code_q - CODE_INIT_MIN) : code_q[BLK_W-1:0];
  assign wr_block = (is_data(code_q) || is_init(code_q)) && (wn != '0);

  assign waddr_full = WORD_W'(i_cfg.write_start) + WORD_W'(WORD_W'(wn - BLK_FIRST) * BLK_WORDS_W)
                    + WORD_W'(i_out_img.idx - WIDX_FIRST);
  assign raddr_full = WORD_W'(i_cfg.read_start) + WORD_W'(WORD_W'(rb_q - BLK_FIRST) * BLK_WORDS_W)
                    + WORD_W'(cnt_q - CNT_SEND_START);

  assign exp_code = (i_cfg.write_count == '0) ? CODE_NULL : WORD_W'(wb_q);
  assign rd_code  = (i_cfg.read_count == '0) ? CODE_NULL : WORD_W'(rb_q);

  assign recv_end = (state_q == ST_RECV) && i_out_img.valid && (i_out_img.idx == WIDX_TAIL);

  always_comb begin
    state_d     = state_q;
    code_d      = code_q;
    wb_d        = wb_q;
    rb_d        = rb_q;
    cnt_d       = cnt_q;
    adv_d       = adv_q;
    pend_d      = pend_q;
    reply_d     = reply_q;
    warm_d      = 1'b0;
    cold_d      = 1'b0;
    img_d       = '0;
    mem_a.we    = 1'b0;
    mem_a.addr  = '0;
    mem_a.wdata = i_out_img.data;
    case (state_q)
      ST_RECV: begin
        if (i_out_img.valid) begin
          if (i_out_img.idx == WIDX_CODE) begin
            code_d = i_out_img.data;
          end else if ((i_out_img.idx >= WIDX_FIRST) && (i_out_img.idx <= WIDX_LAST_DATA)) begin
            // null and unknown codes never reach the database
            if (wr_block) begin
              mem_a.we   = 1'b1;
              mem_a.addr = waddr_full[DB_AW-1:0];
            end
          end else if (i_out_img.idx == WIDX_TAIL) begin
            state_d = ST_SEND;
            cnt_d   = CNT_SEND_START;
            adv_d   = 1'b1;
            pend_d  = 1'b0;
            if (is_data(code_q) || is_init(code_q)) begin
              wb_d = (wn >= wblocks) ? BLK_FIRST : BLK_W'(wn + BLK_FIRST);
            end else if (is_special(code_q) && (code_q >= CODE_WARM)) begin
              pend_d  = 1'b1;
              reply_d = code_q;
              adv_d   = 1'b0;
            end else if (!is_null(code_q)) begin
              adv_d = 1'b0;
            end
          end
        end
      end
      ST_SEND: begin
        mem_a.addr  = raddr_full[DB_AW-1:0];
        img_d.valid = 1'b1;
        img_d.idx   = cnt_q - CNT_SEND_START;
        if (cnt_q == CNT_SEND_START) begin
          img_d.data = exp_code;
        end else if (cnt_q <= CNT_LAST_DATA) begin
          img_d.data = (i_cfg.read_count == '0) ? CODE_NULL : mem_rdata;
        end else begin
          img_d.data = pend_q ? reply_q : rd_code;
        end
        if (cnt_q == CNT_SEND_END) begin
          state_d = ST_RECV;
          if (adv_q && (rblocks != '0)) begin
            rb_d = (rb_q >= rblocks) ? BLK_FIRST : BLK_W'(rb_q + BLK_FIRST);
          end
          // restart pulses in the same cycle as the confirming image's last word (index 41)
          if (pend_q) begin
            warm_d = (reply_q == CODE_WARM);
            cold_d = (reply_q == CODE_COLD);
            rb_d   = BLK_FIRST;
            wb_d   = BLK_FIRST;
            pend_d = 1'b0;
          end
        end else begin
          cnt_d = cnt_q + CNT_SEND_START;
        end
      end
      default: begin
        state_d = ST_RECV;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_RECV;
      code_q  <= CODE_RESET;
      wb_q    <= BLK_FIRST;
      rb_q    <= BLK_FIRST;
      cnt_q   <= CNT_RESET;
      adv_q   <= 1'b0;
      pend_q  <= 1'b0;
      reply_q <= CODE_RESET;
      img_q   <= '0;
      warm_q  <= 1'b0;
      cold_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      code_q  <= code_d;
      wb_q    <= wb_d;
      rb_q    <= rb_d;
      cnt_q   <= cnt_d;
      adv_q   <= adv_d;
      pend_q  <= pend_d;
      reply_q <= reply_d;
      img_q   <= img_d;
      warm_q  <= warm_d;
      cold_q  <= cold_d;
    end
  end

  // message path: status code and port-owned special functions only; port-owned ones need a master port
  always_comb begin
    msg_d.done     = i_msg_req.valid;
    msg_d.code     = i_msg_req.code;
    msg_d.accepted = 1'b0;
    case (i_msg_req.code)
      CODE_STATUS: msg_d.accepted = 1'b1;
      CODE_EVT_P1: msg_d.accepted = i_port1_master;
      CODE_EVT_P2: msg_d.accepted = i_port2_master;
      CODE_CMD_P1: msg_d.accepted = i_port1_master;
      CODE_CMD_P2: msg_d.accepted = i_port2_master;
      CODE_ERR_P1: msg_d.accepted = i_port1_master;
      CODE_ERR_P2: msg_d.accepted = i_port2_master;
      CODE_SLV_P1: msg_d.accepted = i_port1_master;
      CODE_SLV_P2: msg_d.accepted = i_port2_master;
      default:     msg_d.accepted = 1'b0;
    endcase
    if (!i_msg_req.valid) begin
      msg_d = '0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      msg_q <= '0;
    end else begin
      msg_q <= msg_d;
    end
  end

  db_ram u_db (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_a       (mem_a),
    .o_a_rdata (mem_rdata),
    .i_b       (i_drv),
    .o_b_rdata (o_drv_rdata)
  );

  assign o_out_ready    = (state_q == ST_RECV);
  assign o_in_img       = img_q;
  assign o_msg_rsp      = msg_q;
  assign o_warm_restart = warm_q;
  assign o_cold_restart = cold_q;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_end_code(logic [WORD_W-1:0] c);
    recv_end && (code_q == c);
  endsequence

  sequence s_frame_open;
    o_in_img.valid && (o_in_img.idx == WIDX_CODE);
  endsequence

  chk_image_length: assert property (
    s_frame_open |-> ##41 (o_in_img.valid && o_in_img.idx == WIDX_TAIL) ##1 !o_in_img.valid)
    else $error("input image not 42 words");

  chk_null_nowrite: assert property (
    mem_a.we |-> !is_null(code_q) && (state_q == ST_RECV))
    else $error("null block wrote the database");

  chk_expect_null: assert property (
    (s_frame_open and (i_cfg.write_count == '0)) |-> (o_in_img.data == CODE_NULL))
    else $error("expected write code not null");

  chk_read_step: assert property (
    (recv_end && (is_null(code_q) || is_data(code_q)) && (rblocks > rb_q))
      |-> ##43 (rb_q == $past(rb_q, 43) + BLK_FIRST))
    else $error("read block did not step");

  chk_unknown_hold: assert property (
    (recv_end && !is_null(code_q) && !is_data(code_q) && !is_init(code_q)
     && (code_q != CODE_WARM) && (code_q != CODE_COLD))
      |-> ##43 (rb_q == $past(rb_q, 43)))
    else $error("unknown code moved read sequence");

  chk_warm_boot: assert property (
    s_end_code(CODE_WARM) |-> !o_warm_restart [*8] ##36 o_warm_restart ##1 !o_warm_restart)
    else $error("warm restart pulse misplaced");

  chk_cold_echo: assert property (
    s_end_code(CODE_COLD) |-> ##43 (o_in_img.idx == WIDX_TAIL && o_in_img.data == CODE_COLD
                                   && o_cold_restart))
    else $error("cold request not echoed");

  chk_status_any: assert property (
    (i_msg_req.valid && i_msg_req.code == CODE_STATUS) |=> (o_msg_rsp.done && o_msg_rsp.accepted))
    else $error("status request refused");

  chk_event_role: assert property (
    (i_msg_req.valid && i_msg_req.code == CODE_EVT_P1 && !i_port1_master)
      |=> (o_msg_rsp.done && !o_msg_rsp.accepted))
    else $error("event command taken on slave port");

endmodule

`default_nettype wire

// File: sim/host_proc_model.sv
// processor-side model: sends output images and collects the input image
`timescale 1ns/1ns
`default_nettype none

module host_proc_model
  import blk_xfer_pkg::*;
(
  input  wire logic      i_ref_clk,
  input  wire logic      i_out_ready,
  input  wire img_word_t i_in_img,
  output var img_word_t  o_out_img
);
  logic [WORD_W-1:0] rx_word [0:41];
  int                rx_cnt = 0;

  initial o_out_img = '0;

  always @(posedge i_ref_clk) begin
    if (i_in_img.valid === 1'b1) begin
      rx_word[i_in_img.idx] <= i_in_img.data;
      rx_cnt <= rx_cnt + 1;
    end
  end

  // each idle cycle drops valid and inverts the word on the line, so stale data is never mistaken for fresh
  task automatic idle_word();
    o_out_img <= '{1'b0, ~o_out_img.idx, ~o_out_img.data};
  endtask

  // code word first, 40 data words, spare word closes the image; gap slows the sender
  task automatic send_image(input logic [15:0] code, input logic [3:0] tag, input int gap,
                            output bit ok);
    int w;
    w = 0;
    while (i_out_ready !== 1'b1 && w < 100) begin
      @(posedge i_ref_clk);
      w++;
    end
    rx_cnt = 0;
    for (int k = 0; k < 42; k++) begin
      @(posedge i_ref_clk);
      o_out_img <= '{1'b1, 6'(k), (k == 0) ? code : {tag, 6'h00, 6'(k)}};
      for (int g = 0; g < gap && k < 41; g++) begin
        @(posedge i_ref_clk);
        idle_word();
      end
    end
    @(posedge i_ref_clk);
    idle_word();
    w = 0;
    while (rx_cnt < 42 && w < 120) begin
      @(posedge i_ref_clk);
      w++;
    end
    ok = (rx_cnt == 42);
  endtask
endmodule

`default_nettype wire

// File: sim/block_sequenced_image_transfer_test.sv
// self-checking bench for the image exchange engine
`timescale 1ns/1ns
`default_nettype none

module block_sequenced_image_transfer_test
  import blk_xfer_pkg::*;
;
  logic              i_ref_clk = 1'b0;
  logic              i_reset_n = 1'b0;
  cfg_t              cfg = '{12'h100, 16'h0051, 12'h100, 16'h0051};
  logic              p1_master = 1'b1;
  logic              p2_master = 1'b1;
  img_word_t         out_img;
  logic              out_ready;
  img_word_t         in_img;
  msg_req_t          msg_req = '0;
  msg_rsp_t          msg_rsp;
  db_port_t          drv = '0;
  logic [WORD_W-1:0] drv_rdata;
  logic              warm;
  logic              cold;
  int                n_fail = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  int                warm_hits = 0;
  int                warm_any = 0;
  int                cold_any = 0;
  int                ready_low = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  block_image_xfer dut (
    .i_ref_clk      (i_ref_clk),
    .i_reset_n      (i_reset_n),
    .i_cfg          (cfg),
    .i_port1_master (p1_master),
    .i_port2_master (p2_master),
    .i_out_img      (out_img),
    .o_out_ready    (out_ready),
    .o_in_img       (in_img),
    .i_msg_req      (msg_req),
    .o_msg_rsp      (msg_rsp),
    .i_drv          (drv),
    .o_drv_rdata    (drv_rdata),
    .o_warm_restart (warm),
    .o_cold_restart (cold)
  );

  host_proc_model u_host (
    .i_ref_clk   (i_ref_clk),
    .i_out_ready (out_ready),
    .i_in_img    (in_img),
    .o_out_img   (out_img)
  );

  always @(posedge i_ref_clk) begin
    cycles++;
    if (warm === 1'b1) warm_any++;
    if (cold === 1'b1) cold_any++;
    if (out_ready === 1'b0) ready_low++;
    if (warm === 1'b1 && in_img.valid === 1'b1 && in_img.idx === WIDX_TAIL) warm_hits++;
    if (cycles == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  function automatic logic [15:0] pat(input logic [3:0] t, input int k);
    return {t, 6'h00, 6'(k)};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic image(input logic [15:0] code, input logic [3:0] tag, input int gap,
                       input logic [15:0] w0, input logic [15:0] w41,
                       input logic [3:0] dtag, input bit dzero, input bit skip_w0);
    bit ok;
    ready_low = 0;
    u_host.send_image(code, tag, gap, ok);
    chk("reply length", 16'h0001, {15'h0000, ok});
    chk("ready low cycles", 16'h002A, 16'(ready_low));
    if (!skip_w0) chk("expected write code", w0, u_host.rx_word[0]);
    for (int k = 1; k <= 40; k++)
      chk("read data", dzero ? 16'h0000 : pat(dtag, k), u_host.rx_word[k]);
    chk("read block code", w41, u_host.rx_word[41]);
  endtask

  task automatic drv_read(input logic [11:0] a, input logic [15:0] exp);
    @(posedge i_ref_clk);
    drv <= '{1'b0, a, 16'h0000};
    @(posedge i_ref_clk);
    #1;
    chk("driver read", exp, drv_rdata);
  endtask

  task automatic t_seq_data();
    image(16'h0001, 4'h1, 0, 16'h0002, 16'h0001, 4'h1, 0, 0);
    image(16'h0002, 4'h2, 2, 16'h0003, 16'h0002, 4'h2, 0, 0);
    image(16'h0003, 4'h3, 0, 16'h0001, 16'h0003, 4'h3, 0, 0);
  endtask

  task automatic t_null_unknown();
    for (int k = 1; k <= 40; k++) begin
      @(posedge i_ref_clk);
      drv <= '{1'b1, 12'(12'h100 + k - 1), pat(4'h9, k)};
    end
    @(posedge i_ref_clk);
    drv.we <= 1'b0;
    image(16'hFFFF, 4'h7, 0, 16'h0001, 16'h0001, 4'h9, 0, 0);
    image(16'h0200, 4'h7, 0, 16'h0001, 16'h0002, 4'h2, 0, 0);
    image(16'h2422, 4'h7, 0, 16'h0001, 16'h0002, 4'h2, 0, 0);
  endtask

  task automatic t_init_boot();
    image(16'h03EA, 4'h4, 0, 16'h0003, 16'h0002, 4'h4, 0, 0);
    drv_read(12'h14F, pat(4'h4, 40));
    warm_hits = 0;
    warm_any = 0;
    cold_any = 0;
    image(16'h270E, 4'h5, 0, 16'h0003, 16'h270E, 4'h3, 0, 0);
    chk("warm pulse on word 41", 16'h0001, 16'(warm_hits));
    chk("warm pulse count", 16'h0001, 16'(warm_any));
    chk("cold pulse count", 16'h0000, 16'(cold_any));
    image(16'h270F, 4'h5, 0, 16'h0001, 16'h270F, 4'h9, 0, 0);
    chk("cold pulse count", 16'h0001, 16'(cold_any));
    image(16'h0001, 4'h6, 0, 16'h0002, 16'h0001, 4'h6, 0, 0);
  endtask

  task automatic t_zero_count();
    @(posedge i_ref_clk);
    cfg <= '{12'h100, 16'h0000, 12'h100, 16'h0000};
    image(16'h0000, 4'h7, 0, 16'h0000, 16'h0000, 4'h0, 1, 0);
    image(16'hFFFF, 4'h7, 1, 16'h0000, 16'h0000, 4'h0, 1, 0);
  endtask

  // requests are issued back to back, only when the bench decides to
  task automatic t_message(input logic m1, input logic m2);
    logic [15:0] codes [0:9];
    int          cls [0:9];
    logic        acc;
    codes = '{16'h2422, 16'h26AD, 16'h26B7, 16'h26AE, 16'h26B8,
              16'h26DE, 16'h26DF, 16'h26E8, 16'h26E9, 16'h0005};
    cls = '{0, 1, 2, 1, 2, 1, 2, 1, 2, 3};
    for (int i = 0; i <= 10; i++) begin
      @(posedge i_ref_clk);
      p1_master <= m1;
      p2_master <= m2;
      msg_req <= (i < 10) ? msg_req_t'{1'b1, codes[i]} : msg_req_t'{1'b0, ~codes[9]};
      #1;
      if (i > 0) begin
        acc = (cls[i-1] == 0) || (cls[i-1] == 1 && m1) || (cls[i-1] == 2 && m2);
        chk("message done", 16'h0001, {15'h0000, msg_rsp.done});
        chk("message accepted", {15'h0000, acc}, {15'h0000, msg_rsp.accepted});
        chk("message code", codes[i-1], msg_rsp.code);
      end
    end
    @(posedge i_ref_clk);
    #1;
    chk("message done idle", 16'h0000, {15'h0000, msg_rsp.done});
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    t_seq_data();
    t_null_unknown();
    t_init_boot();
    t_zero_count();
    t_message(1'b1, 1'b0);
    t_message(1'b0, 1'b1);
    report_and_stop();
  end
endmodule

`default_nettype wire
